// ==== hdl/fdsc_top.sv ====
// Drive-side control: command sequencing, ready and protect checks, write gate,
// upper track zone, status and interrupt registers.
// Assumes drive lines are asynchronous and the register master follows the strobe protocol.
`timescale 1ns/1ps
`include "fdsc_cfg.svh"

// Contract
// - Upper track zone high on tracks 44-76, only during read or write.
// - Write gate high only while writing to the diskette.
// - Ready sampled before read or write; proceed only when high.
// - Ready low skips the read or write and raises completion interrupt.
// - Seek runs whatever the ready level.
// - Status bit 7 shows the ready input inverted.
// - Falling write fault while gate high ends write, sets write fault bit.
// - Track zero input low means the head is at track zero.
// - Write command samples write protect; low aborts and sets protect bit.
// - Write track samples init inhibit; low aborts and sets protect bit.
// - Completion interrupt set at end of operation, cleared by new command.
module fdsc_top #(
	parameter logic [`FDSC_CNT_W-1:0] XFER_CYC = `FDSC_XFER_DEF
) (
	input  wire logic              CLK,
	input  wire logic              NRST,
	input  wire logic [3:0]        ADDR,
	input  wire logic [7:0]        WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [7:0]        RDATA,
	input  wire fdsc_pkg::fdsc_drv_t DRV,
	output logic                   WRITE_GATE_OUT,
	output logic                   UPPER_TRACK_ZONE,
	output logic                   COMPLETION_IRQ,
	output logic                   IRQ
);
	import fdsc_pkg::*;

	localparam int IDX_CYC = (`FDSC_IDX_NS * `FDSC_CLK_MHZ + 999) / 1000;
	localparam logic [11:0] IDX_LAST = 12'(IDX_CYC - 1);
	localparam logic [`FDSC_CNT_W-1:0] CNT_ONE = `FDSC_CNT_W'(1);

	fdsc_st_t  st_r;
	fdsc_st_t  st_nxt;
	logic [6:0] drv_q;
	fdsc_drv_t ds;
	logic      cmd_load;
	logic      wf_fall;

	////////////////////////////////////////////////////////////////////////////
	// Drive lines through two flops
	fdsc_sync #(
		.W    (7),
		.INIT (`FDSC_DRV_IDLE)
	) u_sync (
		.clk  (CLK),
		.nrst (NRST),
		.d    (DRV),
		.q    (drv_q)
	);
	assign ds = drv_q;

	// Command accepted only when idle; writes while busy are dropped
	assign cmd_load = WR && (ADDR == `FDSC_A_CMD) && (st_r.fsm == S_IDLE);
	// Write fault edge seen while gate is on
	assign wf_fall  = st_r.wg && st_r.wf_prev && !ds.drive_write_fault_n;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [3:0] ev;
		ev     = 4'h0;
		st_nxt = st_r;
		st_nxt.wf_prev = ds.drive_write_fault_n;

		// Register writes
		if (WR && ADDR == `FDSC_A_TRK && st_r.fsm == S_IDLE) begin
			st_nxt.trk = WDATA[6:0];
		end
		if (WR && ADDR == `FDSC_A_IMSK) begin
			st_nxt.imsk = WDATA[3:0];
		end

		// Sequencer
		unique case (st_r.fsm)
			S_IDLE: begin
				if (cmd_load) begin
					st_nxt.cmd   = fdsc_cmd_t'(WDATA[1:0]);
					st_nxt.cirq  = 1'b0;
					st_nxt.st_wf = 1'b0;
					st_nxt.st_wp = 1'b0;
					st_nxt.cnt   = XFER_CYC;
					st_nxt.fsm   = S_CHECK;
				end
			end
			S_CHECK: begin
				if (st_r.cmd == CMD_SEEK) begin
					st_nxt.fsm = S_SEEK;
				end else if (!ds.ready) begin
					st_nxt.fsm = S_DONE;
				end else if (st_r.cmd == CMD_READ) begin
					st_nxt.fsm = S_READ;
				end else if (!ds.write_protect_in_n) begin
					st_nxt.st_wp = 1'b1;
					ev[`FDSC_IS_WP] = 1'b1;
					st_nxt.fsm = S_GATEOFF;
				end else if (st_r.cmd == CMD_WTRK && !ds.disk_init_inhibit_n) begin
					st_nxt.st_wp = 1'b1;
					ev[`FDSC_IS_WP] = 1'b1;
					st_nxt.fsm = S_GATEOFF;
				end else begin
					st_nxt.fsm = S_WRITE;
				end
			end
			S_SEEK: begin
				// Head motion ends when the drive reports seek done
				if (!ds.seek_done_in_n) begin
					if (!ds.track_zero_sense_n) begin
						st_nxt.trk = `FDSC_RST_TRK;
					end
					st_nxt.fsm = S_DONE;
				end
			end
			S_READ: begin
				if (st_r.cnt == CNT_ONE) begin
					st_nxt.fsm = S_DONE;
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_ONE;
				end
			end
			S_WRITE: begin
				if (wf_fall) begin
					st_nxt.st_wf = 1'b1;
					ev[`FDSC_IS_WF] = 1'b1;
					st_nxt.fsm = S_GATEOFF;
				end else if (st_r.cnt == CNT_ONE) begin
					st_nxt.fsm = S_GATEOFF;
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_ONE;
				end
			end
			S_GATEOFF: begin
				// Gate already off here; S_DONE follows one cycle later, completion irq rises two cycles later
				st_nxt.fsm = S_DONE;
			end
			S_DONE: begin
				st_nxt.cirq = 1'b1;
				ev[`FDSC_IS_DONE] = 1'b1;
				st_nxt.fsm = S_IDLE;
			end
			default: begin
				st_nxt.fsm = S_IDLE;
			end
		endcase

		// Gate follows the write state alone
		st_nxt.wg  = (st_nxt.fsm == S_WRITE);
		// Zone output only during transfers on the upper tracks
		st_nxt.utz = (st_nxt.fsm == S_READ || st_nxt.fsm == S_WRITE) &&
			(st_nxt.trk >= `FDSC_TRK_LO) && (st_nxt.trk <= `FDSC_TRK_HI);

		// Index qualified by a low level lasting the minimum time
		if (ds.index_mark_in_n) begin
			st_nxt.idx_cnt  = `FDSC_RST_IDXC;
			st_nxt.idx_seen = 1'b0;
		end else if (st_r.idx_cnt != IDX_LAST) begin
			st_nxt.idx_cnt = st_r.idx_cnt + 12'h001;
		end else if (!st_r.idx_seen) begin
			st_nxt.idx_seen = 1'b1;
			ev[`FDSC_IS_IDX] = 1'b1;
		end

		// Sticky events; a read clears, a new event wins
		if (RD && ADDR == `FDSC_A_IST) begin
			st_nxt.ist = ev;
		end else begin
			st_nxt.ist = st_r.ist | ev;
		end
		st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);

		// Read data for the cycle after the strobe
		st_nxt.rdata = `FDSC_RST_BYTE;
		if (RD) begin
			unique case (ADDR)
				`FDSC_A_CMD: begin
					st_nxt.rdata = {6'h00, st_r.cmd};
				end
				`FDSC_A_STAT: begin
					st_nxt.rdata[`FDSC_ST_NRDY] = !ds.ready;
					st_nxt.rdata[`FDSC_ST_WP]   = st_r.st_wp;
					st_nxt.rdata[`FDSC_ST_WF]   = st_r.st_wf;
					st_nxt.rdata[`FDSC_ST_UTZ]  = st_r.utz;
					st_nxt.rdata[`FDSC_ST_TRK0] = !ds.track_zero_sense_n;
					st_nxt.rdata[`FDSC_ST_IDX]  = !ds.index_mark_in_n;
					st_nxt.rdata[`FDSC_ST_BUSY] = (st_r.fsm != S_IDLE);
				end
				`FDSC_A_TRK: begin
					st_nxt.rdata = {1'b0, st_r.trk};
				end
				`FDSC_A_IST: begin
					st_nxt.rdata = {4'h0, st_r.ist};
				end
				`FDSC_A_IMSK: begin
					st_nxt.rdata = {4'h0, st_r.imsk};
				end
				default: begin
					st_nxt.rdata = `FDSC_RST_BYTE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_r          <= '0;
			st_r.fsm      <= S_IDLE;
			st_r.cmd      <= CMD_SEEK;
			st_r.cnt      <= `FDSC_RST_CNT;
			st_r.trk      <= `FDSC_RST_TRK;
			st_r.wf_prev  <= 1'b1;
			st_r.imsk     <= `FDSC_RST_IMSK;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state flops
	assign RDATA            = st_r.rdata;
	assign WRITE_GATE_OUT   = st_r.wg;
	assign UPPER_TRACK_ZONE = st_r.utz;
	assign COMPLETION_IRQ   = st_r.cirq;
	assign IRQ              = st_r.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	sequence seq_check_rw;
		st_r.fsm == S_CHECK && st_r.cmd != CMD_SEEK;
	endsequence

	sequence seq_report;
		st_r.fsm == S_DONE ##1 st_r.cirq;
	endsequence

	chk_gate_write: assert property (
		st_r.wg == (st_r.fsm == S_WRITE) && (!st_r.wg || $past(st_r.fsm) != S_IDLE))
		else $error("write gate outside write state");

	chk_zone_range: assert property (
		st_r.utz |-> (st_r.trk >= `FDSC_TRK_LO && st_r.trk <= `FDSC_TRK_HI &&
		(st_r.fsm == S_READ || st_r.fsm == S_WRITE)))
		else $error("upper zone output wrong");

	chk_notready_skip: assert property (
		seq_check_rw and !ds.ready |=> !st_r.wg ##0 seq_report)
		else $error("not ready did not skip");

	chk_seek_any: assert property (
		st_r.fsm == S_CHECK && st_r.cmd == CMD_SEEK |=> st_r.fsm == S_SEEK)
		else $error("seek not started");

	chk_status_nrdy: assert property (
		RD && ADDR == `FDSC_A_STAT |=> RDATA[`FDSC_ST_NRDY] == !$past(ds.ready))
		else $error("status bit 7 wrong");

	chk_fault_abort: assert property (
		st_r.fsm == S_WRITE && wf_fall |=> !st_r.wg && st_r.st_wf ##1 seq_report)
		else $error("write fault not handled");

	chk_protect_abort: assert property (
		seq_check_rw and ds.ready && st_r.cmd != CMD_READ && !ds.write_protect_in_n
		|=> st_r.st_wp && !st_r.wg ##1 seq_report)
		else $error("write protect not handled");

	chk_inhibit_abort: assert property (
		seq_check_rw and ds.ready && st_r.cmd == CMD_WTRK && !ds.disk_init_inhibit_n
		|=> st_r.st_wp ##1 st_r.fsm == S_DONE)
		else $error("init inhibit not handled");

	chk_irq_clear: assert property (
		cmd_load |=> !st_r.cirq [*2])
		else $error("completion irq not cleared");

	chk_gate_first: assert property (
		$rose(st_r.cirq) |-> !st_r.wg && !$past(st_r.wg) && !$past(st_r.wg, 2))
		else $error("completion before gate off");

	chk_track_zero: assert property (
		st_r.fsm == S_SEEK && !ds.seek_done_in_n && !ds.track_zero_sense_n
		|=> st_r.trk == `FDSC_RST_TRK)
		else $error("track zero not taken");

endmodule

// ==== hdl/fdsc_cfg.svh ====
// Constants of the drive-side control block: register offsets, bit positions, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef FDSC_CFG_SVH
`define FDSC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define FDSC_A_CMD   4'h0
`define FDSC_A_STAT  4'h1
`define FDSC_A_TRK   4'h2
`define FDSC_A_IST   4'h3
`define FDSC_A_IMSK  4'h4

////////////////////////////////////////////////////////////////////////////////
// Status register bit positions
`define FDSC_ST_BUSY 0
`define FDSC_ST_IDX  1
`define FDSC_ST_TRK0 2
`define FDSC_ST_UTZ  3
`define FDSC_ST_WF   5
`define FDSC_ST_WP   6
`define FDSC_ST_NRDY 7

// Interrupt status and mask bit positions
`define FDSC_IS_DONE 0
`define FDSC_IS_IDX  1
`define FDSC_IS_WF   2
`define FDSC_IS_WP   3

////////////////////////////////////////////////////////////////////////////////
// Reset values and widths
`define FDSC_RST_TRK   7'h00
`define FDSC_RST_IMSK  4'h0
`define FDSC_RST_CNT   16'h0000
`define FDSC_RST_IDXC  12'h000
`define FDSC_RST_BYTE  8'h00
`define FDSC_DRV_IDLE  7'h7F
`define FDSC_CNT_W     16
`define FDSC_XFER_DEF  16'h0040

////////////////////////////////////////////////////////////////////////////////
// Upper track zone and timing
`define FDSC_TRK_LO    7'h2C
`define FDSC_TRK_HI    7'h4C
`define FDSC_CLK_MHZ   200
`define FDSC_IDX_NS    10000

`endif

// ==== hdl/fdsc_pkg.sv ====
// Types shared by the drive-side control block.
// Assumes the constants header sits beside it on the include path.
`include "fdsc_cfg.svh"

package fdsc_pkg;

	// Command codes held in the command register
	typedef enum logic [1:0] {
		CMD_SEEK  = 2'b00,
		CMD_READ  = 2'b01,
		CMD_WRITE = 2'b10,
		CMD_WTRK  = 2'b11
	} fdsc_cmd_t;

	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_CHECK   = 3'b001,
		S_SEEK    = 3'b010,
		S_READ    = 3'b011,
		S_WRITE   = 3'b100,
		S_GATEOFF = 3'b101,
		S_DONE    = 3'b110
	} fdsc_state_t;

	// Drive status lines, all but ready active low
	typedef struct packed {
		logic ready;
		logic drive_write_fault_n;
		logic track_zero_sense_n;
		logic index_mark_in_n;
		logic write_protect_in_n;
		logic disk_init_inhibit_n;
		logic seek_done_in_n;
	} fdsc_drv_t;

	// Whole state of the top module
	typedef struct packed {
		fdsc_state_t             fsm;
		fdsc_cmd_t               cmd;
		logic [`FDSC_CNT_W-1:0]  cnt;
		logic [6:0]              trk;
		logic                    wg;
		logic                    utz;
		logic                    cirq;
		logic                    wf_prev;
		logic [11:0]             idx_cnt;
		logic                    idx_seen;
		logic                    st_wf;
		logic                    st_wp;
		logic [3:0]              ist;
		logic [3:0]              imsk;
		logic                    irq;
		logic [7:0]              rdata;
	} fdsc_st_t;

endpackage

// ==== hdl/fdsc_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ps

module fdsc_sync #(
	parameter int         W    = 7,
	parameter logic [W-1:0] INIT = '1
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// Both stages held in one state word
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] outq;
	} fdsc_sync_st_t;

	fdsc_sync_st_t st_r;
	fdsc_sync_st_t st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt.meta = d;
		st_nxt.outq = st_r.meta;
	end

	// Stage register, both stages start at the idle level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= {INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Output straight from the second stage
	assign q = st_r.outq;

endmodule

// ==== sim/fdsc_drive_model.sv ====
// Drive model: status lines of one floppy drive facing the control block.
// Assumes the bench steers its controls at rising clock edges.
`timescale 1ns/1ps

module fdsc_drive_model (
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire logic           wg,
	input  wire logic           rdy,
	input  wire logic           wp_n,
	input  wire logic           inh_n,
	input  wire logic           trk0,
	input  wire logic           f_arm,
	input  wire logic           sk_go,
	input  wire logic           ix_go,
	output fdsc_pkg::fdsc_drv_t drv
);
	import fdsc_pkg::*;
	logic        flt_n_r;
	logic [5:0]  sk_r;
	logic [11:0] ix_r;

	////////////////////////////////////////////////////////////////////////////////
	// Fault only while gate is up, seek settles after 20 cycles, index held 2100 cycles
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flt_n_r <= 1'b1;
			sk_r    <= 6'h00;
			ix_r    <= 12'h000;
		end else begin
			flt_n_r <= !(f_arm && wg);
			sk_r    <= sk_go ? sk_r + {5'h00, sk_r != 6'h3F} : 6'h00;
			ix_r    <= ix_go ? 12'h834 : ix_r - {11'h000, ix_r != 12'h000};
		end
	end

	// Line levels, track zero pulled low at track 00
	assign drv = '{ready: rdy, drive_write_fault_n: flt_n_r, track_zero_sense_n: !trk0,
		index_mark_in_n: ix_r == 12'h000, write_protect_in_n: wp_n, disk_init_inhibit_n: inh_n,
		seek_done_in_n: sk_r < 6'h14};
endmodule

// ==== sim/floppy_drive_side_control_bench.sv ====
// Self-checking bench of the drive-side control block.
// Assumes the design files and the drive model are compiled first.
`timescale 1ns/1ps
`include "fdsc_cfg.svh"

module floppy_drive_side_control_bench;
	import fdsc_pkg::*;
	localparam logic [15:0] XF = 16'h0010;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_d = 1'b0;
	logic [7:0]  rdata;
	fdsc_drv_t   drv;
	logic        wg, utz, cirq, irq;
	logic        rdy = 1'b1, wp_n = 1'b1, inh_n = 1'b1, trk0 = 1'b0;
	logic        f_arm = 1'b0, sk_go = 1'b0, ix_go = 1'b0;
	logic [15:0] expq[$];
	logic [15:0] e;
	logic [31:0] seed = 32'h5FDF26DE;
	logic [6:0]  t;
	logic [17:0] tbl [8];
	logic [6:0]  trk_tab [4];
	int          bad_count = 0;
	int          check_count = 0;
	int          gc, uc, k;

	always #2.5 clk = ~clk;

	fdsc_top #(.XFER_CYC(XF)) uut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .DRV(drv), .WRITE_GATE_OUT(wg), .UPPER_TRACK_ZONE(utz), .COMPLETION_IRQ(cirq), .IRQ(irq));
	fdsc_drive_model drive (.clk(clk), .nrst(nrst), .wg(wg), .rdy(rdy), .wp_n(wp_n), .inh_n(inh_n), .trk0(trk0),
		.f_arm(f_arm), .sk_go(sk_go), .ix_go(ix_go), .drv(drv));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
		check_count++;
		if (got !== ex) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, ex, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Register bus cycles, a read notes its masked expectation
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		expq.push_back({m, ex & m});
		@(posedge clk);
		rd <= 1'b0;
	endtask

	// Issue a command and count gate and zone cycles until completion
	task automatic op(input logic [1:0] c);
		gc = 0;
		uc = 0;
		k = 0;
		repeat (4) @(posedge clk);
		wreg(`FDSC_A_CMD, {6'h00, c});
		@(posedge clk);
		#1;
		chk("completion cleared", 16'h0000, {15'h0000, cirq});
		// The first transfer cycle already stands here, count it too
		gc += int'(wg === 1'b1);
		uc += int'(utz === 1'b1);
		while (k < 400 && cirq !== 1'b1) begin
			@(posedge clk);
			#1;
			k++;
			gc += int'(wg === 1'b1);
			uc += int'(utz === 1'b1);
		end
		chk("completion", 16'h0001, {15'h0000, cirq});
		chk("gate at completion", 16'h0000, {15'h0000, wg});
	endtask

	// Read data watcher, takes the oldest note
	always @(posedge clk) begin
		if (rd_d) begin
			e = expq.pop_front();
			chk("read data", {8'h00, e[7:0]}, {8'h00, rdata & e[15:8]});
		end
		rd_d <= rd;
	end

	// Watchdog
	initial begin
		#200000;
		bad_count++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tbl = '{{CMD_READ, 3'b011, 1'b0, 8'h80, 4'h1}, {CMD_WRITE, 3'b011, 1'b0, 8'h80, 4'h1},
			{CMD_WRITE, 3'b101, 1'b0, 8'h40, 4'h9}, {CMD_WTRK, 3'b101, 1'b0, 8'h40, 4'h9},
			{CMD_WTRK, 3'b110, 1'b0, 8'h40, 4'h9}, {CMD_WRITE, 3'b110, 1'b1, 8'h00, 4'h1},
			{CMD_READ, 3'b111, 1'b0, 8'h00, 4'h1}, {CMD_WTRK, 3'b111, 1'b1, 8'h00, 4'h1}};
		trk_tab = '{7'h2B, 7'h2C, 7'h4C, 7'h4D};
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rreg(`FDSC_A_STAT, 8'hFF, 8'h00);
		seed = xs(seed);
		wreg(`FDSC_A_IMSK, seed[7:0]);
		rreg(`FDSC_A_IMSK, 8'h0F, seed[7:0]);
		wreg(`FDSC_A_IMSK, 8'h01);
		// Ready, protect and inhibit cases with interrupt raise and clear
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rdy   <= tbl[i][15];
			wp_n  <= tbl[i][14];
			inh_n <= tbl[i][13];
			op(tbl[i][17:16]);
			chk("gate cycles", tbl[i][12] ? XF : 16'h0000, gc[15:0]);
			repeat (2) @(posedge clk);
			#1 chk("irq raised", 16'h0001, {15'h0000, irq});
			rreg(`FDSC_A_STAT, 8'hE1, tbl[i][11:4]);
			rreg(`FDSC_A_IST, 8'h0D, {4'h0, tbl[i][3:0]});
			repeat (3) @(posedge clk);
			#1 chk("irq cleared", 16'h0000, {15'h0000, irq});
		end
		// Zone boundaries and random tracks, irq masked
		wreg(`FDSC_A_IMSK, 8'h00);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			t = (i < 4) ? trk_tab[i] : seed[6:0];
			wreg(`FDSC_A_TRK, {1'b0, t});
			op(i[0] ? CMD_WRITE : CMD_READ);
			chk("zone cycles", (t >= `FDSC_TRK_LO && t <= `FDSC_TRK_HI) ? XF : 16'h0000, uc[15:0]);
			chk("gate cycles", i[0] ? XF : 16'h0000, gc[15:0]);
		end
		chk("irq masked", 16'h0000, {15'h0000, irq});
		// Write fault in mid-transfer
		@(posedge clk);
		f_arm <= 1'b1;
		op(CMD_WRITE);
		chk("fault cut", 16'h0001, {15'h0000, gc > 0 && gc < int'(XF)});
		rreg(`FDSC_A_STAT, 8'h21, 8'h20);
		rreg(`FDSC_A_IST, 8'h04, 8'h04);
		// Slow seek while not ready, head reaches track zero
		f_arm <= 1'b0;
		rdy   <= 1'b0;
		trk0  <= 1'b1;
		sk_go <= 1'b1;
		op(CMD_SEEK);
		rreg(`FDSC_A_TRK, 8'h7F, 8'h00);
		// Index pulse qualified
		sk_go <= 1'b0;
		ix_go <= 1'b1;
		@(posedge clk);
		ix_go <= 1'b0;
		repeat (2200) @(posedge clk);
		rreg(`FDSC_A_IST, 8'h02, 8'h02);
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule
